// file: taf_regs.svh
// Register offsets, field positions, unlock keys and timing counts.
// Assumes a 32-bit APB slave on a 100 MHz system clock.
`ifndef TAF_REGS_SVH
`define TAF_REGS_SVH

`define TAF_OFS_CONTROL   8'h00
`define TAF_OFS_UNLOCK    8'h04
`define TAF_OFS_LATCH     8'h08
`define TAF_OFS_PTR_LOW   8'h0C
`define TAF_OFS_PTR_HIGH  8'h10
`define TAF_OFS_PTR_UPPER 8'h14
`define TAF_OFS_TABLE_OP  8'h18

`define TAF_BIT_TWO_BYTE  5
`define TAF_BIT_ROW_ERASE 4
`define TAF_BIT_ABORT     3
`define TAF_BIT_GATE      2
`define TAF_BIT_START     1

`define TAF_UNLOCK_FIRST  8'h55
`define TAF_UNLOCK_SECOND 8'hAA

`define TAF_OP_STORE_BIT  0
`define TAF_CLK_MHZ       100
`define TAF_PROG_TIME_US  1000

`endif

// file: taf_pkg.sv
// Types shared by the table access flash control block.
// Assumes taf_regs.svh for numeric constants.
package taf_pkg;
    typedef enum logic [1:0] {
        TAF_PTR_KEEP,
        TAF_PTR_POST_INC,
        TAF_PTR_POST_DEC,
        TAF_PTR_PRE_INC
    } taf_ptr_mode_e;

    typedef enum {
        TAF_IDLE,
        TAF_FETCH,
        TAF_PROG,
        TAF_ERASE,
        TAF_WAIT
    } taf_state_e;
endpackage

// file: taf_table_access_flash_control.sv
// Table access and self-timed flash program/erase sequencer, APB slave.
// Assumes a flash macro on the same clock returning read data one cycle
// after flash_rd_o.
`timescale 1ns/1ps
`include "taf_regs.svh"

module taf_table_access_flash_control
    import taf_pkg::*;
#(
    parameter int PROG_CYCLES = `TAF_PROG_TIME_US * `TAF_CLK_MHZ
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  flash_rdata_i,
    output logic      [21:0] flash_addr_o,
    output logic             flash_rd_o,
    output logic      [7:0]  flash_wdata_o,
    output logic             flash_wr_o,
    output logic             flash_erase_o,
    output logic             fetch_stall_o
);

    typedef struct packed {
        taf_state_e       state;
        logic             two_byte;
        logic             row_erase;
        logic             abort;
        logic             gate;
        logic             start;
        logic [1:0]       unlock_step;
        logic [7:0]       latch;
        logic [21:0]      ptr;
        logic [63:0][7:0] hold;
        logic [5:0]       idx;
        logic [31:0]      timer;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic [21:0]      faddr;
        logic             frd;
        logic [7:0]       fwdata;
        logic             fwr;
        logic             ferase;
        logic             stall;
    } taf_state_s;

    taf_state_s st;
    taf_state_s next_st;

    function automatic logic [21:0] taf_step(input logic [21:0] p,
                                             input logic        down);
        logic [20:0] low;
        low = down ? (p[20:0] - 21'h1) : (p[20:0] + 21'h1);
        return {p[21], low};
    endfunction

    logic          wr_access;
    logic          unmapped;
    logic [7:0]    rd_byte;
    logic [7:0]    wbyte;
    logic [21:0]   eff;
    taf_ptr_mode_e mode;
    logic [5:0]    hidx;

    always_comb begin
        next_st   = st;
        wbyte     = pwdata_i[7:0];
        mode      = taf_ptr_mode_e'(pwdata_i[2:1]);
        wr_access = psel_i && penable_i && st.pready && pwrite_i;
        unmapped  = 1'b0;
        rd_byte   = 8'h00;
        eff       = (mode == TAF_PTR_PRE_INC) ? taf_step(st.ptr, 1'b0)
                                              : st.ptr;
        hidx      = st.two_byte ? {st.ptr[5:1], st.idx[0]} : st.idx;
        next_st.fwr    = 1'b0;
        next_st.ferase = 1'b0;
        next_st.frd    = 1'b0;

        case (paddr_i)
            `TAF_OFS_CONTROL:   rd_byte = {2'b00, st.two_byte, st.row_erase,
                                           st.abort, st.gate, st.start,
                                           1'b0};
            `TAF_OFS_UNLOCK:    rd_byte = 8'h00;
            `TAF_OFS_LATCH:     rd_byte = st.latch;
            `TAF_OFS_PTR_LOW:   rd_byte = st.ptr[7:0];
            `TAF_OFS_PTR_HIGH:  rd_byte = st.ptr[15:8];
            `TAF_OFS_PTR_UPPER: rd_byte = {2'b00, st.ptr[21:16]};
            `TAF_OFS_TABLE_OP:  rd_byte = 8'h00;
            default:            unmapped = 1'b1;
        endcase

        // Bus held off while the sequencer is busy, which halts the core
        next_st.pready = psel_i && !st.pready && (st.state == TAF_IDLE);
        if (next_st.pready) begin
            next_st.prdata  = {24'h000000, rd_byte};
            next_st.pslverr = unmapped;
        end else if (st.pready) begin
            next_st.prdata  = 32'h00000000;
            next_st.pslverr = 1'b0;
        end

        if (wr_access && !unmapped) begin
            case (paddr_i)
                `TAF_OFS_CONTROL: begin
                    next_st.two_byte  = wbyte[`TAF_BIT_TWO_BYTE];
                    next_st.row_erase = wbyte[`TAF_BIT_ROW_ERASE];
                    next_st.abort     = wbyte[`TAF_BIT_ABORT];
                    next_st.gate      = wbyte[`TAF_BIT_GATE];
                    if (wbyte[`TAF_BIT_START]) begin
                        next_st.abort       = 1'b1;
                        next_st.unlock_step = 2'd0;
                        // Launch only when gated on and unlocked
                        if (wbyte[`TAF_BIT_GATE] && st.gate &&
                            st.unlock_step == 2'd2) begin
                            next_st.start = 1'b1;
                            next_st.idx   = 6'd0;
                            next_st.stall = 1'b1;
                            next_st.state = wbyte[`TAF_BIT_ROW_ERASE]
                                          ? TAF_ERASE : TAF_PROG;
                        end
                    end
                end
                `TAF_OFS_UNLOCK: begin
                    if (wbyte == `TAF_UNLOCK_FIRST)
                        next_st.unlock_step = 2'd1;
                    else if (wbyte == `TAF_UNLOCK_SECOND &&
                             st.unlock_step == 2'd1)
                        next_st.unlock_step = 2'd2;
                    else
                        next_st.unlock_step = 2'd0;
                end
                `TAF_OFS_LATCH:     next_st.latch = wbyte;
                `TAF_OFS_PTR_LOW:   next_st.ptr[7:0]   = wbyte;
                `TAF_OFS_PTR_HIGH:  next_st.ptr[15:8]  = wbyte;
                `TAF_OFS_PTR_UPPER: next_st.ptr[21:16] = wbyte[5:0];
                `TAF_OFS_TABLE_OP: begin
                    case (mode)
                        TAF_PTR_KEEP:     next_st.ptr = st.ptr;
                        TAF_PTR_POST_DEC: next_st.ptr = taf_step(st.ptr, 1'b1);
                        default:          next_st.ptr = taf_step(st.ptr, 1'b0);
                    endcase
                    if (wbyte[`TAF_OP_STORE_BIT]) begin
                        // Latch byte lands in a holding register only
                        next_st.hold[eff[5:0]] = st.latch;
                    end else begin
                        next_st.faddr = eff;
                        next_st.frd   = 1'b1;
                        next_st.state = TAF_FETCH;
                    end
                end
                default: ;
            endcase
        end

        case (st.state)
            TAF_IDLE: ;
            TAF_FETCH: begin
                // Flash answers the cycle after its strobe; wait that out
                if (!st.frd) begin
                    // Raw flash byte kept as is in the latch
                    next_st.latch = flash_rdata_i;
                    next_st.state = TAF_IDLE;
                end
            end
            TAF_PROG: begin
                next_st.fwr    = 1'b1;
                next_st.fwdata = st.hold[hidx];
                next_st.faddr  = {st.ptr[21:6], hidx};
                next_st.idx    = st.idx + 6'd1;
                if ((st.two_byte && st.idx == 6'd1) ||
                    st.idx == 6'd63) begin
                    next_st.state = TAF_WAIT;
                    next_st.timer = PROG_CYCLES;
                end
            end
            TAF_ERASE: begin
                next_st.ferase = 1'b1;
                next_st.faddr  = {st.ptr[21:10], 10'h000};
                next_st.state  = TAF_WAIT;
                next_st.timer  = PROG_CYCLES;
            end
            TAF_WAIT: begin
                next_st.timer = st.timer - 32'd1;
                if (st.timer <= 32'd1) begin
                    next_st.state     = TAF_IDLE;
                    next_st.start     = 1'b0;
                    next_st.abort     = 1'b0;
                    next_st.row_erase = 1'b0;
                    next_st.stall     = 1'b0;
                end
            end
            default: next_st.state = TAF_IDLE;
        endcase

        if (reset_i) begin
            next_st       = '0;
            next_st.state = TAF_IDLE;
            // Flag survives a reset that cuts an operation short
            next_st.abort = (st.state == TAF_PROG || st.state == TAF_ERASE ||
                             st.state == TAF_WAIT) || st.abort;
            next_st.gate  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st <= next_st;
    end

    assign prdata_o      = st.prdata;
    assign pready_o      = st.pready;
    assign pslverr_o     = st.pslverr;
    assign flash_addr_o  = st.faddr;
    assign flash_rd_o    = st.frd;
    assign flash_wdata_o = st.fwdata;
    assign flash_wr_o    = st.fwr;
    assign flash_erase_o = st.ferase;
    assign fetch_stall_o = st.stall;

endmodule // taf_table_access_flash_control

// file: taf_flash_model.sv
// Flash array model on the far side of the table access block.
// Assumes read data is due the cycle after the read strobe.
`timescale 1ns/1ps
module taf_flash_model (
    input  wire logic        sys_clk_i,
    input  wire logic        flash_rd_i,
    input  wire logic        flash_wr_i,
    input  wire logic        flash_erase_i,
    input  wire logic [21:0] flash_addr_i,
    input  wire logic [7:0]  flash_wdata_i,
    output logic      [7:0]  flash_rdata_o
);
    int          n_wr      = 0;
    int          n_erase   = 0;
    logic [21:0] last_addr = 22'h0;
    logic [7:0]  last_data = 8'h00;

    always @(posedge sys_clk_i) begin
        // One byte per read, chosen by address bits 7:0 and 21
        if (flash_rd_i) begin
            flash_rdata_o <= flash_addr_i[7:0] ^ {flash_addr_i[21], 7'h00};
        end else begin
            flash_rdata_o <= ~flash_rdata_o;
        end
        if (flash_wr_i || flash_erase_i) begin
            last_addr <= flash_addr_i;
            last_data <= flash_wdata_i;
        end
        if (flash_wr_i) begin
            n_wr <= n_wr + 1;
        end
        if (flash_erase_i) begin
            n_erase <= n_erase + 1;
        end
    end
endmodule // taf_flash_model

// file: taf_props.sv
// Port checker for the table access flash control block.
// Assumes it is bound to the top module with PROG_CYCLES passed on.
`timescale 1ns/1ps
module taf_props #(
    parameter int PROG_CYCLES = 8
) (
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic [21:0] flash_addr_o,
    input wire logic        flash_rd_o,
    input wire logic        flash_wr_o,
    input wire logic        flash_erase_o,
    input wire logic        fetch_stall_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence

    rd_one_shot_a: assert property (flash_rd_o |-> s_pulse(flash_rd_o))
        else $error("fetch strobe longer than one cycle");
    erase_row_a: assert property (flash_erase_o |->
        flash_addr_o[9:0] == 10'h000 && fetch_stall_o)
        else $error("erase not on a row base or not stalled");
    stall_bound_a: assert property ($rose(fetch_stall_o) |->
        ##[1:200] !fetch_stall_o) else $error("stall did not end");
    stall_quiet_a: assert property (fetch_stall_o |-> !pready_o)
        else $error("transfer answered while stalled");
    wr_timed_a: assert property (flash_wr_o |-> fetch_stall_o)
        else $error("array write outside a timed operation");
    unlock_zero_a: assert property (pready_o && !pwrite_i &&
        paddr_i == 8'h04 |-> prdata_o == 32'h0)
        else $error("unlock port read not zero");
    ctl_unused_a: assert property (pready_o && !pwrite_i &&
        paddr_i == 8'h00 |-> prdata_o[7:6] == 2'b00 && !prdata_o[0])
        else $error("unused control bits not zero");
    rd_narrow_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("read data wider than a byte");
endmodule // taf_props

// file: tb_top.sv
// Self-checking bench for the table access flash control block.
// Assumes the flash model on the far side and the checker bound below.
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0;
    logic [31:0] prdata_o, rd;
    logic [21:0] flash_addr_o;
    logic [7:0]  flash_rdata_i, flash_wdata_o;
    logic        pready_o, pslverr_o, flash_rd_o, flash_wr_o, err;
    logic        flash_erase_o, fetch_stall_o;
    int          failures  = 0;
    int          n_tests   = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    taf_table_access_flash_control #(.PROG_CYCLES(8))
        i_taf_table_access_flash_control (.sys_clk_i, .reset_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .flash_rdata_i, .flash_addr_o, .flash_rd_o,
        .flash_wdata_o, .flash_wr_o, .flash_erase_o, .fetch_stall_o);
    taf_flash_model i_taf_flash_model (.sys_clk_i, .flash_rd_i(flash_rd_o),
        .flash_wr_i(flash_wr_o), .flash_erase_i(flash_erase_o),
        .flash_addr_i(flash_addr_o), .flash_wdata_i(flash_wdata_o),
        .flash_rdata_o(flash_rdata_i));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge sys_clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= {24'h0, d};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk_i);
            i++;
        end while (pready_o !== 1'b1 && i < 500);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            failures++;
            summarize();
        end
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(n, {24'h0, e}, rd);
    endtask

    task automatic set_ptr(input logic [7:0] u, h, l);
        apb(1'b1, 8'h14, u);
        apb(1'b1, 8'h10, h);
        apb(1'b1, 8'h0C, l);
    endtask

    task automatic unlock();
        apb(1'b1, 8'h04, 8'h55);
        apb(1'b1, 8'h04, 8'hAA);
    endtask

    task automatic sc_reset_values();
        apb(1'b0, 8'h00, 8'h00);
        // Abort flag powers up unknown; every other bit starts clear
        chk("control", 32'h0, rd & 32'hFFFFFFF7);
        rdchk("unlock", 8'h04, 8'h00);
        apb(1'b0, 8'h40, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, err});
    endtask

    task automatic sc_fetch_modes();
        logic [7:0] op[4] = '{8'h00, 8'h02, 8'h04, 8'h06};
        logic [7:0] lat[4] = '{8'h85, 8'h85, 8'h85, 8'h86};
        logic [7:0] lo[4] = '{8'h05, 8'h06, 8'h04, 8'h06};
        for (int k = 0; k < 4; k++) begin
            set_ptr(8'h20, 8'h00, 8'h05);
            apb(1'b1, 8'h18, op[k]);
            rdchk("latch", 8'h08, lat[k]);
            rdchk("pointer low", 8'h0C, lo[k]);
        end
        set_ptr(8'h3F, 8'hFF, 8'hFF);
        apb(1'b1, 8'h18, 8'h02);
        rdchk("latch top", 8'h08, 8'h7F);
        rdchk("pointer upper", 8'h14, 8'h20);
        rdchk("pointer low", 8'h0C, 8'h00);
    endtask

    task automatic sc_program();
        apb(1'b1, 8'h00, 8'h02);
        rdchk("improper start", 8'h00, 8'h08);
        set_ptr(8'h00, 8'h01, 8'h02);
        apb(1'b1, 8'h08, 8'h5A);
        apb(1'b1, 8'h18, 8'h03);
        apb(1'b1, 8'h08, 8'hC3);
        apb(1'b1, 8'h18, 8'h01);
        chk("writes after store", 32'h0, i_taf_flash_model.n_wr);
        apb(1'b1, 8'h00, 8'h04);
        for (int k = 1; k <= 2; k++) begin
            unlock();
            apb(1'b1, 8'h00, 8'h26);
            rdchk("control done", 8'h00, 8'h24);
            chk("write count", 2 * k, i_taf_flash_model.n_wr);
            chk("last byte", 32'hC3, i_taf_flash_model.last_data);
            chk("last address", 32'h103, i_taf_flash_model.last_addr);
        end
        // Full 64-byte block program
        apb(1'b1, 8'h00, 8'h04);
        unlock();
        apb(1'b1, 8'h00, 8'h06);
        rdchk("block done", 8'h00, 8'h04);
        chk("block count", 32'h44, i_taf_flash_model.n_wr);
        chk("block end", 32'h13F, i_taf_flash_model.last_addr);
    endtask

    task automatic sc_erase();
        set_ptr(8'h00, 8'h0A, 8'hBC);
        apb(1'b1, 8'h00, 8'h14);
        unlock();
        apb(1'b1, 8'h00, 8'h16);
        rdchk("erase done", 8'h00, 8'h04);
        chk("erase address", 32'h800, i_taf_flash_model.last_addr);
        chk("erase count", 32'h1, i_taf_flash_model.n_erase);
        unlock();
        apb(1'b1, 8'h00, 8'h16);
        @(posedge sys_clk_i);
        chk("stall", 32'h1, {31'h0, fetch_stall_o});
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rdchk("abort kept", 8'h00, 8'h08);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        sc_reset_values();
        sc_fetch_modes();
        sc_program();
        sc_erase();
        summarize();
    end
endmodule // tb_top

bind taf_table_access_flash_control taf_props #(.PROG_CYCLES(PROG_CYCLES))
    i_taf_props (.sys_clk_i, .reset_i, .pwrite_i, .paddr_i, .prdata_o,
    .pready_o, .flash_addr_o, .flash_rd_o, .flash_wr_o, .flash_erase_o,
    .fetch_stall_o);
